// [rtl/fps_defs.svh]
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH

// Clock rate and power-up times in their own units
`define FPS_CLK_MHZ          40
`define FPS_FAST_READ_US     100
`define FPS_FAST_WRITE_US    500
`define FPS_FULL_ACCESS_US   600
`define FPS_WRITE_UNLOCK_US  10
`define FPS_SEL_SUPPLY_US    10

// Cycle counts; integer MHz keeps every product exact
`define FPS_FAST_READ_CYC    (`FPS_FAST_READ_US * `FPS_CLK_MHZ)
`define FPS_FAST_WRITE_CYC   (`FPS_FAST_WRITE_US * `FPS_CLK_MHZ)
`define FPS_FULL_ACCESS_CYC  (`FPS_FULL_ACCESS_US * `FPS_CLK_MHZ)
`define FPS_WRITE_UNLOCK_CYC (`FPS_WRITE_UNLOCK_US * `FPS_CLK_MHZ)
`define FPS_SEL_SUPPLY_CYC   (`FPS_SEL_SUPPLY_US * `FPS_CLK_MHZ)

// Widths
`define FPS_TMR_W            16
`define FPS_SYNC_W           6
`define FPS_SEL_W            5
`define FPS_SEL_MAX          5'h1F

// Rescue selection lengths in serial clocks
`define FPS_RESC_A           5'h07
`define FPS_RESC_B           5'h0D
`define FPS_RESC_C           5'h19
`define FPS_RESC_D           5'h08

// Field positions and reset values
`define FPS_NV_FASTPOR_BIT   5
`define FPS_NV_FASTPOR_RST   1'b0
`define FPS_LOCK_WR_BIT      0
`define FPS_LOCK_DN_BIT      1
`define FPS_STATUS_INIT      8'h00
`define FPS_STATUS_PAD       6'h00
`define FPS_BLANK_BYTE       8'hFF

`endif

// [rtl/fps_pkg.sv]
`default_nettype none

package fps_pkg;

    typedef enum logic [2:0] {
        CMD_READ            = 3'b000,
        CMD_STATUS_POLL     = 3'b001,
        CMD_VOL_CFG_WRITE   = 3'b010,
        CMD_WRITE_ENABLE    = 3'b011,
        CMD_MODIFY          = 3'b100,
        CMD_NV_CONFIG_WRITE = 3'b101,
        CMD_LOCK_WRITE      = 3'b110
    } fps_cmd_t;

    typedef enum logic [2:0] {
        ST_OFF    = 3'b000,
        ST_BOOT   = 3'b001,
        ST_READ   = 3'b010,
        ST_PHASE2 = 3'b011,
        ST_FULL   = 3'b100
    } fps_state_t;

    typedef enum logic [1:0] {
        RS_PART1A = 2'b00,
        RS_PART1B = 2'b01,
        RS_PART1C = 2'b10,
        RS_PART2  = 2'b11
    } fps_resc_t;

    typedef struct packed {
        logic        valid;
        fps_cmd_t    kind;
        logic [15:0] data;
    } fps_req_t;

    typedef struct packed {
        logic deepPowerDown;
        logic writeLock;
        logic lockDown;
        logic writeEnableLatch;
        logic writeInProgressFlag;
    } fps_flags_t;

endpackage : fps_pkg
`default_nettype wire

// [rtl/fps_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module fps_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;

    // Two stages; only the second stage is visible outside
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule : fps_sync
`default_nettype wire

// [rtl/fps_timer.sv]
`timescale 1ns/10ps
`default_nettype none

module fps_timer #(
    parameter int unsigned LIMIT = 1,
    parameter int          W     = 16
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    output logic      done
);

    logic [W-1:0] cnt_q;

    // Saturating count; dropping run restarts the delay
    assign done = (cnt_q >= W'(LIMIT));

    always_ff @(posedge clk) begin
        if (rst || !run) begin
            cnt_q <= '0;
        end else if (!done) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

endmodule : fps_timer
`default_nettype wire

// [rtl/fps_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fps_defs.svh"

// Notes on behaviour
// - Below threshold, held reset and silent
// - Write enable and modify wait unlock delay; fast mode takes write enable after the fast read delay
// - Reads served after select delay, unlock pending
// - Power-up: standby, latches clear, locks zero
// - Supply loss disables everything, no response
// - Fast mode: reads, volatile writes within 100us
// - Normal mode: fully accessible within 600us of supply
// - Fast mode: first write enable starts phase
// - Second phase rejects all but status polling
// - Phase sets both flags; latch survives end
// - Nonvolatile bit 5 selects fast power-on
// - Rescue forces plain SPI until power-up
// - Part one: 7, 13, 25 clocks, io0 high
// - Part two: 8 clocks, io0 and io3 high
// - Blank bytes read FFh, status reads 00h at power-up
// - Fast mode writes accepted 500us after the first write enable

module fps_top #(
    parameter int unsigned FULL_ACCESS_CYC  = `FPS_FULL_ACCESS_CYC,
    parameter int unsigned FAST_WRITE_CYC   = `FPS_FAST_WRITE_CYC,
    parameter int unsigned FAST_READ_CYC    = `FPS_FAST_READ_CYC,
    parameter int unsigned WRITE_UNLOCK_CYC = `FPS_WRITE_UNLOCK_CYC,
    parameter int unsigned SEL_SUPPLY_CYC   = `FPS_SEL_SUPPLY_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              supplyGoodPin,
    input  wire logic              supplyMinPin,
    input  wire logic              serialClkPin,
    input  wire logic              selectNPin,
    input  wire logic              serialIo0Pin,
    input  wire logic              serialIo3Pin,
    input  wire fps_pkg::fps_req_t cmdReq,
    output logic                   logicReset,
    output logic                   readAllowed,
    output logic                   writeAllowed,
    output logic                   secondPhase,
    output logic                   cmdAccept,
    output logic                   cmdReject,
    output fps_pkg::fps_flags_t    flags,
    output logic [7:0]             statusByte,
    output logic [7:0]             blankByte,
    output logic                   fastPorActive,
    output logic                   xipExit,
    output logic                   forceSpi
);

    logic [`FPS_SYNC_W-1:0] pinSync;
    logic                   supplyGood;
    logic                   supplyMin;
    logic                   sck;
    logic                   selectN;
    logic                   selActive;
    logic                   io0;
    logic                   io3;
    logic                   sckPrev_q;
    logic                   selPrev_q;
    logic                   vslDone;
    logic                   puwDone;
    logic                   vtrDone;
    logic                   vtwDone;
    logic                   dtwDone;
    fps_pkg::fps_state_t    state_q;
    fps_pkg::fps_state_t    state_d;
    fps_pkg::fps_flags_t    flags_q;
    fps_pkg::fps_flags_t    flags_d;
    fps_pkg::fps_resc_t     stage_q;
    fps_pkg::fps_resc_t     stage_d;
    logic [`FPS_SEL_W-1:0]  selCnt_q;
    logic                   io0Hi_q;
    logic                   io3Hi_q;
    logic                   nvFastPor_q;
    logic                   fastPor_q;
    logic                   logicReset_q;
    logic                   readAllowed_q;
    logic                   writeAllowed_q;
    logic                   secondPhase_q;
    logic                   cmdAccept_q;
    logic                   cmdReject_q;
    logic [7:0]             statusByte_q;
    logic [7:0]             blankByte_q;
    logic                   xipExit_q;
    logic                   forceSpi_q;

    // Kinds that consume the write-enable latch
    function automatic logic needsLatch(input fps_pkg::fps_cmd_t k);
        needsLatch = (k == fps_pkg::CMD_MODIFY) || (k == fps_pkg::CMD_NV_CONFIG_WRITE)
                  || (k == fps_pkg::CMD_LOCK_WRITE);
    endfunction : needsLatch

    // All pins are asynchronous to clk, including the serial clock
    // Select enters inverted so a reset stage reads as deselected, no false edge
    fps_sync #(
        .WIDTH (`FPS_SYNC_W)
    ) uSync (
        .clk  (clk),
        .rst  (rst),
        .din  ({supplyGoodPin, supplyMinPin, serialClkPin, ~selectNPin,
                serialIo0Pin, serialIo3Pin}),
        .dout (pinSync)
    );
    assign {supplyGood, supplyMin, sck, selActive, io0, io3} = pinSync;
    assign selectN = ~selActive;

    // Power-up delays; each restarts when its supply level drops
    fps_timer #(.LIMIT(SEL_SUPPLY_CYC), .W(`FPS_TMR_W)) uVsl (
        .clk (clk), .rst (rst), .run (supplyGood & supplyMin), .done (vslDone));
    fps_timer #(.LIMIT(WRITE_UNLOCK_CYC), .W(`FPS_TMR_W)) uPuw (
        .clk (clk), .rst (rst), .run (supplyGood), .done (puwDone));
    fps_timer #(.LIMIT(FAST_READ_CYC), .W(`FPS_TMR_W)) uVtr (
        .clk (clk), .rst (rst), .run (supplyGood & supplyMin), .done (vtrDone));
    fps_timer #(.LIMIT(FULL_ACCESS_CYC), .W(`FPS_TMR_W)) uVtw (
        .clk (clk), .rst (rst), .run (supplyGood & supplyMin), .done (vtwDone));
    fps_timer #(.LIMIT(FAST_WRITE_CYC), .W(`FPS_TMR_W)) uDtw (
        .clk (clk), .rst (rst), .run (state_q == fps_pkg::ST_PHASE2), .done (dtwDone));

    // Command classification
    wire isRead    = cmdReq.kind == fps_pkg::CMD_READ;
    wire isPoll    = cmdReq.kind == fps_pkg::CMD_STATUS_POLL;
    wire isVolCfg  = cmdReq.kind == fps_pkg::CMD_VOL_CFG_WRITE;
    wire isWren    = cmdReq.kind == fps_pkg::CMD_WRITE_ENABLE;
    wire isNvCfg   = cmdReq.kind == fps_pkg::CMD_NV_CONFIG_WRITE;
    wire isLock    = cmdReq.kind == fps_pkg::CMD_LOCK_WRITE;
    wire modClass  = needsLatch(cmdReq.kind);
    wire readClass = isRead | isPoll | isVolCfg;
    wire reqValid  = cmdReq.valid & supplyGood;

    // Acceptance per power-up stage; modify needs the latch
    wire inRead    = state_q == fps_pkg::ST_READ;
    wire inPhase2  = state_q == fps_pkg::ST_PHASE2;
    wire inFull    = state_q == fps_pkg::ST_FULL;
    wire inOff     = state_q == fps_pkg::ST_OFF;
    wire acceptNow = (inRead & (readClass | (isWren & fastPor_q)))
                   | (inPhase2 & isPoll)
                   | (inFull & (~modClass | flags_q.writeEnableLatch));
    wire takeCmd   = reqValid & ~inOff & acceptNow;
    wire dropCmd   = reqValid & ~inOff & ~acceptNow;
    wire enterPh2  = takeCmd & inRead & isWren;
    wire takeFull  = takeCmd & inFull;
    wire readOk    = fastPor_q ? vtrDone : vslDone;
    wire fullOk    = (puwDone & vslDone) | vtwDone;

    // Power-up sequence; fast mode waits for a write enable
    always_comb begin
        state_d = state_q;
        case (state_q)
            fps_pkg::ST_OFF: begin
                state_d = fps_pkg::ST_BOOT;
            end
            fps_pkg::ST_BOOT: begin
                if (readOk) begin
                    state_d = fps_pkg::ST_READ;
                end
            end
            fps_pkg::ST_READ: begin
                if (enterPh2) begin
                    state_d = fps_pkg::ST_PHASE2;
                end else if (!fastPor_q && fullOk) begin
                    state_d = fps_pkg::ST_FULL;
                end
            end
            fps_pkg::ST_PHASE2: begin
                if (dtwDone) begin
                    state_d = fps_pkg::ST_FULL;
                end
            end
            fps_pkg::ST_FULL: begin
                state_d = fps_pkg::ST_FULL;
            end
            default: begin
                state_d = fps_pkg::ST_OFF;
            end
        endcase
        if (!supplyGood) begin
            state_d = fps_pkg::ST_OFF;
        end
    end

    // Status flags; cleared while the supply is low
    always_comb begin
        flags_d = flags_q;
        if (!supplyGood || inOff) begin
            flags_d = '0;
        end else if (enterPh2) begin
            flags_d.writeEnableLatch    = 1'b1;
            flags_d.writeInProgressFlag = 1'b1;
        end else if (inPhase2 && dtwDone) begin
            flags_d.writeInProgressFlag = 1'b0;
        end else if (takeFull) begin
            if (isWren) begin
                flags_d.writeEnableLatch = 1'b1;
            end
            if (modClass) begin
                flags_d.writeEnableLatch = 1'b0;
            end
            if (isLock) begin
                flags_d.writeLock = cmdReq.data[`FPS_LOCK_WR_BIT];
                flags_d.lockDown  = cmdReq.data[`FPS_LOCK_DN_BIT];
            end
        end
    end

    // Sequencer state and flags
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= fps_pkg::ST_OFF;
            flags_q <= '0;
        end else begin
            state_q <= state_d;
            flags_q <= flags_d;
        end
    end

    // Nonvolatile bit survives supply loss; sampled while powered off
    always_ff @(posedge clk) begin
        if (rst) begin
            nvFastPor_q <= `FPS_NV_FASTPOR_RST;
            fastPor_q   <= `FPS_NV_FASTPOR_RST;
        end else begin
            if (takeFull && isNvCfg) begin
                nvFastPor_q <= cmdReq.data[`FPS_NV_FASTPOR_BIT];
            end
            if (!supplyGood) begin
                fastPor_q <= nvFastPor_q;
            end
        end
    end

    // Serial clock and select edges seen through the synchroniser
    wire sckRise  = sck & ~sckPrev_q;
    wire deselect = selectN & ~selPrev_q;
    wire m7       = (selCnt_q == `FPS_RESC_A) & io0Hi_q;
    wire m13      = (selCnt_q == `FPS_RESC_B) & io0Hi_q;
    wire m25      = (selCnt_q == `FPS_RESC_C) & io0Hi_q;
    wire m8       = (selCnt_q == `FPS_RESC_D) & io0Hi_q & io3Hi_q;

    // Per-selection clock count and held-high tracking
    always_ff @(posedge clk) begin
        if (rst || !supplyGood || deselect) begin
            selCnt_q <= '0;
            io0Hi_q  <= 1'b1;
            io3Hi_q  <= 1'b1;
        end else if (!selectN && sckRise) begin
            selCnt_q <= (selCnt_q == `FPS_SEL_MAX) ? selCnt_q : selCnt_q + 1'b1;
            io0Hi_q  <= io0Hi_q & io0;
            io3Hi_q  <= io3Hi_q & io3;
        end
    end

    // Rescue progress; a wrong length in part one restarts it, part two holds
    always_comb begin
        stage_d = stage_q;
        if (deselect) begin
            case (stage_q)
                fps_pkg::RS_PART1A: begin
                    stage_d = m7 ? fps_pkg::RS_PART1B : fps_pkg::RS_PART1A;
                end
                fps_pkg::RS_PART1B: begin
                    stage_d = m13 ? fps_pkg::RS_PART1C
                            : (m7 ? fps_pkg::RS_PART1B : fps_pkg::RS_PART1A);
                end
                fps_pkg::RS_PART1C: begin
                    stage_d = m25 ? fps_pkg::RS_PART2
                            : (m7 ? fps_pkg::RS_PART1B : fps_pkg::RS_PART1A);
                end
                fps_pkg::RS_PART2: begin
                    stage_d = fps_pkg::RS_PART2;
                end
                default: begin
                    stage_d = fps_pkg::RS_PART1A;
                end
            endcase
        end
    end

    // Rescue results hold until the next power-up
    always_ff @(posedge clk) begin
        if (rst || !supplyGood) begin
            stage_q    <= fps_pkg::RS_PART1A;
            xipExit_q  <= 1'b0;
            forceSpi_q <= 1'b0;
        end else begin
            stage_q <= stage_d;
            if (deselect && stage_q == fps_pkg::RS_PART1C && m25) begin
                xipExit_q <= 1'b1;
            end
            if (deselect && stage_q == fps_pkg::RS_PART2 && m8) begin
                forceSpi_q <= 1'b1;
            end
        end
    end

    // Edge history
    always_ff @(posedge clk) begin
        if (rst) begin
            sckPrev_q <= 1'b0;
            selPrev_q <= 1'b1;
        end else begin
            sckPrev_q <= sck;
            selPrev_q <= selectN;
        end
    end

    // Registered outputs; access levels lag the state by one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            logicReset_q   <= 1'b1;
            readAllowed_q  <= 1'b0;
            writeAllowed_q <= 1'b0;
            secondPhase_q  <= 1'b0;
            cmdAccept_q    <= 1'b0;
            cmdReject_q    <= 1'b0;
            statusByte_q   <= `FPS_STATUS_INIT;
            blankByte_q    <= `FPS_BLANK_BYTE;
        end else begin
            logicReset_q   <= ~supplyGood;
            readAllowed_q  <= inRead | inFull;
            writeAllowed_q <= inFull;
            secondPhase_q  <= inPhase2;
            cmdAccept_q    <= takeCmd;
            cmdReject_q    <= dropCmd;
            statusByte_q   <= {`FPS_STATUS_PAD, flags_q.writeEnableLatch,
                               flags_q.writeInProgressFlag};
            blankByte_q    <= `FPS_BLANK_BYTE;
        end
    end

    assign logicReset    = logicReset_q;
    assign readAllowed   = readAllowed_q;
    assign writeAllowed  = writeAllowed_q;
    assign secondPhase   = secondPhase_q;
    assign cmdAccept     = cmdAccept_q;
    assign cmdReject     = cmdReject_q;
    assign flags         = flags_q;
    assign statusByte    = statusByte_q;
    assign blankByte     = blankByte_q;
    assign fastPorActive = fastPor_q;
    assign xipExit       = xipExit_q;
    assign forceSpi      = forceSpi_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_off_silent;
        !supplyGood |=> !cmdAccept_q && !cmdReject_q && state_q == fps_pkg::ST_OFF;
    endproperty
    a_off_silent: assert property (p_off_silent)
        else $error("answer given while supply low");

    property p_write_enable_cmd_early;
        supplyGood && cmdReq.valid && isWren && (state_q == fps_pkg::ST_BOOT
            || (inRead && !fastPor_q)) |=> cmdReject_q && !flags_q.writeEnableLatch;
    endproperty
    a_write_enable_cmd_early: assert property (p_write_enable_cmd_early)
        else $error("write enable taken before unlock");

    property p_read_served;
        supplyGood && cmdReq.valid && isRead && inRead |=> cmdAccept_q;
    endproperty
    a_read_served: assert property (p_read_served)
        else $error("read refused after select delay");

    property p_powerup_flags;
        inOff ##1 state_q == fps_pkg::ST_BOOT |-> flags_q == '0 && statusByte_q == `FPS_STATUS_INIT;
    endproperty
    a_powerup_flags: assert property (p_powerup_flags)
        else $error("flags not clear after power-up");

    property p_fast_read;
        supplyGood && fastPor_q && vtrDone && state_q == fps_pkg::ST_BOOT
            |=> inRead ##1 readAllowed_q;
    endproperty
    a_fast_read: assert property (p_fast_read)
        else $error("fast read stage not reached");

    property p_full_access;
        supplyGood && !fastPor_q && vtwDone && inRead && !enterPh2 |=> inFull ##1 writeAllowed_q;
    endproperty
    a_full_access: assert property (p_full_access)
        else $error("not fully accessible by deadline");

    property p_phase2_enter;
        supplyGood && inRead && fastPor_q && cmdReq.valid && isWren
            |=> inPhase2 && flags_q.writeEnableLatch && flags_q.writeInProgressFlag;
    endproperty
    a_phase2_enter: assert property (p_phase2_enter)
        else $error("second phase not started");

    property p_phase2_reject;
        supplyGood && inPhase2 && cmdReq.valid && !isPoll |=> cmdReject_q && !cmdAccept_q;
    endproperty
    a_phase2_reject: assert property (p_phase2_reject)
        else $error("command taken in second phase");

    property p_phase2_end;
        supplyGood && inPhase2 && dtwDone
            |=> inFull && flags_q.writeEnableLatch && !flags_q.writeInProgressFlag;
    endproperty
    a_phase2_end: assert property (p_phase2_end)
        else $error("second phase ended wrongly");

    property p_nv_bit;
        supplyGood && inFull && cmdReq.valid && isNvCfg && flags_q.writeEnableLatch
            |=> nvFastPor_q == $past(cmdReq.data[`FPS_NV_FASTPOR_BIT]);
    endproperty
    a_nv_bit: assert property (p_nv_bit)
        else $error("fast power-on bit not stored");

    property p_rescue_hold;
        xipExit_q && supplyGood |=> xipExit_q;
    endproperty
    a_rescue_hold: assert property (p_rescue_hold)
        else $error("rescue state lost while powered");

    property p_part1;
        supplyGood && deselect && stage_q == fps_pkg::RS_PART1C && m25
            |=> xipExit_q && stage_q == fps_pkg::RS_PART2;
    endproperty
    a_part1: assert property (p_part1)
        else $error("rescue part one not completed");

    property p_part2;
        supplyGood && deselect && stage_q == fps_pkg::RS_PART2 && m8 |=> forceSpi_q;
    endproperty
    a_part2: assert property (p_part2)
        else $error("rescue part two not completed");

    property p_count_restart;
        deselect |=> selCnt_q == '0 && io0Hi_q;
    endproperty
    a_count_restart: assert property (p_count_restart)
        else $error("clock count not restarted");

    c_phase2: cover property (inRead ##1 inPhase2);
    c_full_plain: cover property (!fastPor_q && inRead ##1 inFull);
    c_xip_exit: cover property ($rose(xipExit_q));
    c_force_spi: cover property ($rose(forceSpi_q));

endmodule : fps_top
`default_nettype wire

// [testbench/fps_host_model.sv]
`timescale 1ns/10ps
`default_nettype none

// Host end of the link; its clock runs only inside frames
module fps_host_model (
    output logic serialClk,
    output logic selectN,
    output logic io0,
    output logic io3
);
    // Idle: deselected, clock parked low
    initial begin
        serialClk = 1'b0;
        selectN   = 1'b1;
        io0       = 1'b0;
        io3       = 1'b0;
    end

    // One selection of n clocks, io0 high, io3 high only when both is set
    task frame(input int n, input logic both);
        selectN = 1'b0;
        io0 = 1'b1;
        io3 = both;
        repeat (n) begin
            #100 serialClk = 1'b1;
            #100 serialClk = 1'b0;
        end
        #100 selectN = 1'b1;
        // Released lines flip so a stale value never passes
        io0 = 1'b0;
        io3 = ~both;
        #200; // Deselect far above the minimum
    endtask : frame
endmodule : fps_host_model
`default_nettype wire

// [testbench/fps_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module fps_top_tb;
    logic clk = 1'b0, rst = 1'b1, good = 1'b0, vmin = 1'b0;
    logic sck, selN, io0, io3;
    logic readAllowed, writeAllowed, secondPhase, cmdAccept, cmdReject;
    logic logicReset, fastPorActive, xipExit, forceSpi;
    logic [7:0] statusByte, blankByte;
    fps_pkg::fps_req_t   req = '0;
    fps_pkg::fps_flags_t flags;
    int errors = 0, num_checks = 0, cycles = 0;

    fps_top #(.FULL_ACCESS_CYC(60), .FAST_WRITE_CYC(50), .FAST_READ_CYC(20),
              .WRITE_UNLOCK_CYC(30), .SEL_SUPPLY_CYC(10)) u_fps_top (
        .clk(clk), .rst(rst), .supplyGoodPin(good), .supplyMinPin(vmin),
        .serialClkPin(sck), .selectNPin(selN), .serialIo0Pin(io0),
        .serialIo3Pin(io3), .cmdReq(req), .logicReset(logicReset),
        .readAllowed(readAllowed), .writeAllowed(writeAllowed),
        .secondPhase(secondPhase), .cmdAccept(cmdAccept), .cmdReject(cmdReject),
        .flags(flags), .statusByte(statusByte), .blankByte(blankByte),
        .fastPorActive(fastPorActive), .xipExit(xipExit), .forceSpi(forceSpi));
    fps_host_model u_fps_host_model (.serialClk(sck), .selectN(selN), .io0(io0), .io3(io3));

    // 40 MHz clock; timeout guards a hung wait
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end

    task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One-cycle command pulse; answer looked at one cycle later
    task cmd(input fps_pkg::fps_cmd_t k, input logic [15:0] d, input logic [1:0] exp);
        @(posedge clk) #1 req = '{1'b1, k, d};
        @(posedge clk) #1 req.valid = 1'b0;
        chk("answer", {14'h0, cmdAccept, cmdReject}, {14'h0, exp});
    endtask : cmd

    // Bounded wait for a stage level
    task waitHi(input logic wr);
        int n;
        n = 0;
        while ((wr ? writeAllowed : readAllowed) !== 1'b1 && n < 400) begin
            @(posedge clk) #1 n++;
        end
        chk("stage", {15'h0, n < 400}, 16'h1);
    endtask : waitHi

    task summarize;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    // Main sequence: slow power-up, fast power-up, rescue
    initial begin
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("reset", {logicReset, 10'h0, flags}, 16'h8000);
        chk("bytes", {blankByte, statusByte}, 16'hFF00);
        cmd(fps_pkg::CMD_READ, 16'h0, 2'b00);
        good = 1'b1;
        vmin = 1'b1;
        waitHi(1'b0);
        cmd(fps_pkg::CMD_READ, 16'h0, 2'b10);
        cmd(fps_pkg::CMD_WRITE_ENABLE, 16'h0, 2'b01);
        waitHi(1'b1);
        cmd(fps_pkg::CMD_MODIFY, 16'h0, 2'b01);
        cmd(fps_pkg::CMD_WRITE_ENABLE, 16'h0, 2'b10);
        cmd(fps_pkg::CMD_NV_CONFIG_WRITE, 16'h0020, 2'b10);
        cmd(fps_pkg::CMD_WRITE_ENABLE, 16'h0, 2'b10);
        cmd(fps_pkg::CMD_LOCK_WRITE, 16'h0003, 2'b10);
        chk("lock", {11'h0, flags}, 16'h000C);
        good = 1'b0;
        vmin = 1'b0;
        repeat (5) @(posedge clk);
        #1 chk("loss", {logicReset, readAllowed, 9'h0, flags}, 16'h8000);
        good = 1'b1;
        vmin = 1'b1;
        waitHi(1'b0);
        chk("fast", {15'h0, fastPorActive}, 16'h1);
        cmd(fps_pkg::CMD_VOL_CFG_WRITE, 16'h0, 2'b10);
        cmd(fps_pkg::CMD_WRITE_ENABLE, 16'h0, 2'b10);
        @(posedge clk) #1 chk("phase", {secondPhase, 7'h0, statusByte}, 16'h8003);
        cmd(fps_pkg::CMD_READ, 16'h0, 2'b01);
        cmd(fps_pkg::CMD_STATUS_POLL, 16'h0, 2'b10);
        waitHi(1'b1);
        chk("end", {11'h0, flags}, 16'h0002);
        u_fps_host_model.frame(7, 1'b0);
        u_fps_host_model.frame(13, 1'b0);
        u_fps_host_model.frame(25, 1'b0);
        repeat (6) @(posedge clk);
        #1 chk("xip", {14'h0, xipExit, forceSpi}, 16'h2);
        u_fps_host_model.frame(8, 1'b1);
        repeat (6) @(posedge clk);
        #1 chk("spi", {14'h0, xipExit, forceSpi}, 16'h3);
        cmd(fps_pkg::CMD_NV_CONFIG_WRITE, 16'h0000, 2'b10);
        summarize();
    end
endmodule : fps_top_tb
`default_nettype wire
